//--- rtl/ccsm_top.sv
// clock source select, glitch-free switch, clock monitor and oscillator control
// What this block does
// - reset routes the internal clock to the output
// - monitor on and a source inactive forces the live side, deselects the dead one
// - surviving clock appears one to two of its cycles after inactivity changes
// - source select write lands only if target is on and stable
// - monitor enable sets only with both clocks on and stable
// - monitor interrupt enable sets only with monitor already enabled
// - monitor flag clearing starts with a read that sees it set
// - inactive selected source flips the readable select to the live source
// - monitor flag reads at bit 6 of the control register
// - oscillator period set only by stage control and divider code
// - divider divides the switched and monitored clock by two to the code, codes above 9 act as 9; internal_osc_clock stays undivided
// - divider code moves only by carry or borrow of stage control
// - upper three stage bits give 17 to 31 ring stages, step two
// - coarse correction steps stage control by one unit of bit 5
// - lower five stage bits give long cycles per 32
// - switch runs old clock, holds low, then follows new clock
// - detector flags inactive after two empty reference-low windows
// - external stable sets after 4096 external cycles, clears when off or inactive
`timescale 1ns/1ps
module ccsm_top #(
    parameter int REF_HALF = 40000   // system cycles per reference half period
) (
    input  wire logic        aclk,                 // system clock, 100 MHz
    input  wire logic        aresetn,              // synchronous reset, active low
    input  wire logic        ce,                   // clock enable
    input  wire logic        external_osc_clock,   // external clock, sampled
    input  wire logic        internal_freq_ok,     // internal clock within target band
    input  wire logic        corr_up,              // loop filter lengthens period
    input  wire logic        corr_down,            // loop filter shortens period
    input  wire logic        corr_coarse,          // error above 15 percent
    output logic             internal_osc_clock,   // generated internal clock
    output logic             selected_osc_output,  // switched oscillator output
    output logic             monitor_irq,          // monitor interrupt request
    input  wire logic [7:0]  s_axi_awaddr,         // write address
    input  wire logic        s_axi_awvalid,        // write address valid
    output logic             s_axi_awready,        // write address ready
    input  wire logic [31:0] s_axi_wdata,          // write data
    input  wire logic [3:0]  s_axi_wstrb,          // write strobes
    input  wire logic        s_axi_wvalid,         // write data valid
    output logic             s_axi_wready,         // write data ready
    output logic [1:0]       s_axi_bresp,          // write response
    output logic             s_axi_bvalid,         // write response valid
    input  wire logic        s_axi_bready,         // write response ready
    input  wire logic [7:0]  s_axi_araddr,         // read address
    input  wire logic        s_axi_arvalid,        // read address valid
    output logic             s_axi_arready,        // read address ready
    output logic [31:0]      s_axi_rdata,          // read data
    output logic [1:0]       s_axi_rresp,          // read response
    output logic             s_axi_rvalid,         // read data valid
    input  wire logic        s_axi_rready          // read data ready
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic        cs;
        logic        int_on;
        logic        ext_on;
        logic        mon_en;
        logic        mon_ie;
        logic        mon_flag;
        logic        flag_seen;
        logic [11:0] stab_cnt;
        logic        ext_stable;
        logic [1:0]  isync;
        logic [1:0]  esync;
        logic        internal_osc_clock_prev;
        logic        external_osc_clock_prev;
        logic        clk_out;
        logic [7:0]  stage;
        logic [3:0]  div;
        logic [7:0]  ring_cnt;
        logic        ring_ph;
        logic [4:0]  dith_cnt;
        logic [8:0]  div_cnt;
        logic [31:0] ref_cnt;
        logic        ref_low;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ccsm_state_s;

    ccsm_state_s s_q;
    ccsm_state_s s_d;

    logic [1:0] inact;
    logic [1:0] falls;
    logic       internal_osc_clock_now;
    logic       int_stable;
    logic       force_int;
    logic       force_ext;
    logic [3:0] div_eff;
    logic [7:0] ring_len;

    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction : fell

    // ****************************************************************
    // activity detectors: 0 internal, 1 external
    // ****************************************************************
    logic [1:0] watched;
    assign watched = {external_osc_clock, internal_osc_clock_now};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_act
            ccsm_activity u_act (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .ce       (ce),
                .mon_clk  (watched[gi]),
                .ref_low  (s_q.ref_low),
                .inactive (inact[gi]),
                .fall     (falls[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // oscillator and combinational terms
    // ****************************************************************
    always_comb begin
        div_eff  = (s_q.div > ccsm_pkg::DIV_MAX) ? ccsm_pkg::DIV_MAX : s_q.div;
        ring_len = ccsm_pkg::RING_BASE + {4'h0, s_q.stage[7:5], 1'b0};
        if (s_q.dith_cnt < s_q.stage[4:0]) begin
            ring_len = ring_len + ccsm_pkg::DITHER_ADD;
        end
        if (div_eff == 4'h0) begin
            internal_osc_clock_now = s_q.ring_ph;
        end else begin
            internal_osc_clock_now = s_q.div_cnt[div_eff - 4'h1];
        end
    end

    assign int_stable = s_q.int_on & internal_freq_ok & ~inact[0];
    assign force_int  = s_q.mon_en & inact[1];
    assign force_ext  = s_q.mon_en & inact[0] & ~inact[1];

    assign internal_osc_clock  = s_q.ring_ph;
    assign selected_osc_output = s_q.clk_out;
    assign monitor_irq         = s_q.mon_flag & s_q.mon_ie;
    assign s_axi_awready = ce & ~s_q.aw_got & ~s_q.bvalid;
    assign s_axi_wready  = ce & ~s_q.w_got & ~s_q.bvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = ce & ~s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [7:0]  wd;
        logic [7:0]  ctrl_rd;
        logic [11:0] digitally_controlled_osc;
        logic        tgt;
        logic        want_int;
        logic        want_ext;
        wd       = 8'h00;
        ctrl_rd  = 8'h00;
        digitally_controlled_osc      = {s_q.div, s_q.stage};
        tgt      = 1'b0;
        want_int = 1'b0;
        want_ext = 1'b0;
        s_d      = s_q;

        // reference clock for the monitors
        if (s_q.ref_cnt >= 32'(REF_HALF - 1)) begin
            s_d.ref_cnt = 32'h0;
            s_d.ref_low = ~s_q.ref_low;
        end else begin
            s_d.ref_cnt = s_q.ref_cnt + 32'h1;
        end

        // ring oscillator, dither and binary divider
        if (s_q.int_on) begin
            if (s_q.ring_cnt >= ring_len - 8'h1) begin
                s_d.ring_cnt = 8'h00;
                s_d.ring_ph  = ~s_q.ring_ph;
                if (s_q.ring_ph) begin
                    s_d.dith_cnt = s_q.dith_cnt + 5'h01;
                    s_d.div_cnt  = s_q.div_cnt + 9'h001;
                end
            end else begin
                s_d.ring_cnt = s_q.ring_cnt + 8'h01;
            end
        end

        // loop filter corrections on the combined divider and stage value
        if (corr_up != corr_down) begin
            if (corr_up) begin
                if (digitally_controlled_osc <= ccsm_pkg::DCO_MAX - (corr_coarse ? ccsm_pkg::STEP_COARSE : ccsm_pkg::STEP_FINE)) begin
                    digitally_controlled_osc = digitally_controlled_osc + (corr_coarse ? ccsm_pkg::STEP_COARSE : ccsm_pkg::STEP_FINE);
                end
            end else if (digitally_controlled_osc >= (corr_coarse ? ccsm_pkg::STEP_COARSE : ccsm_pkg::STEP_FINE)) begin
                digitally_controlled_osc = digitally_controlled_osc - (corr_coarse ? ccsm_pkg::STEP_COARSE : ccsm_pkg::STEP_FINE);
            end
        end
        s_d.stage = digitally_controlled_osc[7:0];
        s_d.div   = digitally_controlled_osc[11:8];

        // external stabilisation count
        s_d.external_osc_clock_prev = external_osc_clock;
        if (!s_q.ext_on || inact[1]) begin
            s_d.stab_cnt   = 12'h000;
            s_d.ext_stable = 1'b0;
        end else if (fell(s_q.external_osc_clock_prev, external_osc_clock) && !s_q.ext_stable) begin
            if (s_q.stab_cnt == ccsm_pkg::STAB_LAST) begin
                s_d.ext_stable = 1'b1;
            end else begin
                s_d.stab_cnt = s_q.stab_cnt + 12'h001;
            end
        end

        // ****************************************************************
        // register bus
        // ****************************************************************
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_got && s_q.w_got) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = ccsm_pkg::RESP_OKAY;
            if (s_q.awaddr == ccsm_pkg::CTRL_ADDR) begin
                if (s_q.wstrb[0]) begin
                    wd         = s_q.wdata[7:0];
                    s_d.ext_on = wd[ccsm_pkg::EXT_ON_BIT];
                    s_d.int_on = wd[ccsm_pkg::INT_ON_BIT] | ~s_q.cs;
                    tgt        = wd[ccsm_pkg::CS_BIT];
                    if (tgt ? (s_q.ext_on & s_q.ext_stable) : (s_q.int_on & int_stable)) begin
                        s_d.cs = tgt;
                    end
                    s_d.mon_en = wd[ccsm_pkg::MON_EN_BIT] & s_q.int_on & s_q.ext_on
                                 & int_stable & s_q.ext_stable;
                    s_d.mon_ie = wd[ccsm_pkg::MON_IE_BIT] & s_q.mon_en;
                    if (s_q.flag_seen && !wd[ccsm_pkg::MON_FLG_BIT]) begin
                        s_d.mon_flag = 1'b0;
                    end
                    s_d.flag_seen = 1'b0;
                end
            end else if (s_q.awaddr != ccsm_pkg::DCO_ADDR && s_q.awaddr != ccsm_pkg::STAT_ADDR) begin
                s_d.bresp = ccsm_pkg::RESP_SLVERR;
            end
        end

        ctrl_rd[ccsm_pkg::EXT_STB_BIT] = s_q.ext_stable;
        ctrl_rd[ccsm_pkg::EXT_ON_BIT]  = s_q.ext_on;
        ctrl_rd[ccsm_pkg::INT_STB_BIT] = int_stable;
        ctrl_rd[ccsm_pkg::INT_ON_BIT]  = s_q.int_on;
        ctrl_rd[ccsm_pkg::CS_BIT]      = s_q.cs;
        ctrl_rd[ccsm_pkg::MON_EN_BIT]  = s_q.mon_en;
        ctrl_rd[ccsm_pkg::MON_FLG_BIT] = s_q.mon_flag;
        ctrl_rd[ccsm_pkg::MON_IE_BIT]  = s_q.mon_ie;
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = ccsm_pkg::RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            if (s_axi_araddr == ccsm_pkg::CTRL_ADDR) begin
                s_d.rdata[7:0] = ctrl_rd;
                if (s_q.mon_flag) begin
                    s_d.flag_seen = 1'b1;
                end
            end else if (s_axi_araddr == ccsm_pkg::DCO_ADDR) begin
                s_d.rdata[7:0]                  = s_q.stage;
                s_d.rdata[ccsm_pkg::DIV_LSB+:4] = s_q.div;
            end else if (s_axi_araddr == ccsm_pkg::STAT_ADDR) begin
                s_d.rdata[ccsm_pkg::INT_OFF_BIT] = inact[0];
                s_d.rdata[ccsm_pkg::EXT_OFF_BIT] = inact[1];
            end else begin
                s_d.rresp = ccsm_pkg::RESP_SLVERR;
            end
        end

        // ****************************************************************
        // monitor: hardware events win over software writes
        // ****************************************************************
        if (!s_q.ext_on || !s_q.int_on) begin
            s_d.mon_en = 1'b0;
            s_d.mon_ie = 1'b0;
        end
        if (s_q.mon_en && (inact[0] || inact[1])) begin
            s_d.mon_flag = 1'b1;
            if (force_int) begin
                s_d.cs = 1'b0;
            end else begin
                s_d.cs = 1'b1;
            end
        end

        // ****************************************************************
        // glitch-free switch, each side stepped on its own clock's falling edge
        // ****************************************************************
        s_d.internal_osc_clock_prev = internal_osc_clock_now;
        want_int      = (~s_q.cs | force_int) & ~force_ext;
        want_ext      = (s_q.cs | force_ext) & ~force_int;
        if (force_ext) begin
            s_d.isync = 2'b00;
        end else if (fell(s_q.internal_osc_clock_prev, internal_osc_clock_now)) begin
            s_d.isync = {s_q.isync[0], want_int & ~s_q.esync[1]};
        end
        if (force_int) begin
            s_d.esync = 2'b00;
        end else if (falls[1]) begin
            s_d.esync = {s_q.esync[0], want_ext & ~s_q.isync[1]};
        end
        s_d.clk_out = (internal_osc_clock_now & s_q.isync[1]) | (external_osc_clock & s_q.esync[1]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q        <= '0;
            s_q.int_on <= 1'b1;
            s_q.isync  <= 2'b11;
            s_q.stage  <= ccsm_pkg::STAGE_RST;
            s_q.div    <= ccsm_pkg::DIV_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end
endmodule : ccsm_top

//--- rtl/ccsm_pkg.sv
// shared constants of the clock select, monitor and oscillator control block
package ccsm_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0]  CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  DCO_ADDR    = 8'h04;
    localparam logic [7:0]  STAT_ADDR   = 8'h08;
    // control register bit positions
    localparam int          EXT_STB_BIT = 0;
    localparam int          EXT_ON_BIT  = 1;
    localparam int          INT_STB_BIT = 2;
    localparam int          INT_ON_BIT  = 3;
    localparam int          CS_BIT      = 4;
    localparam int          MON_EN_BIT  = 5;
    localparam int          MON_FLG_BIT = 6;
    localparam int          MON_IE_BIT  = 7;
    // dco register fields
    localparam int          DIV_LSB     = 8;
    // status register bits
    localparam int          INT_OFF_BIT = 0;
    localparam int          EXT_OFF_BIT = 1;
    // ****************************************************************
    // reset values and oscillator constants
    // ****************************************************************
    localparam logic [7:0]  STAGE_RST   = 8'h00;
    localparam logic [3:0]  DIV_RST     = 4'h0;
    localparam logic [3:0]  DIV_MAX     = 4'h9;
    localparam logic [11:0] DCO_MAX     = 12'h9FF;
    localparam logic [11:0] STEP_COARSE = 12'h020;
    localparam logic [11:0] STEP_FINE   = 12'h001;
    localparam logic [7:0]  RING_BASE   = 8'h11;
    localparam logic [7:0]  DITHER_ADD  = 8'h02;
    localparam logic [11:0] STAB_LAST   = 12'hFFF;
    localparam logic [1:0]  MISS_LIMIT  = 2'h2;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : ccsm_pkg

//--- rtl/ccsm_activity.sv
// activity detector: flags a clock that shows no falling edge in two reference-low windows
`timescale 1ns/1ps
module ccsm_activity (
    input  wire logic aclk,      // system clock
    input  wire logic aresetn,   // synchronous reset, active low
    input  wire logic ce,        // clock enable, freezes state when low
    input  wire logic mon_clk,   // watched clock, sampled
    input  wire logic ref_low,   // reference clock is low
    output logic      inactive,  // clock judged inactive
    output logic      fall       // falling edge of watched clock seen
);
    typedef struct packed {
        logic       clk_prev;
        logic       ref_prev;
        logic       seen;
        logic [1:0] miss;
        logic       inactive;
    } ccsm_act_s;

    ccsm_act_s s_q;
    ccsm_act_s s_d;

    assign fall     = s_q.clk_prev & ~mon_clk;
    assign inactive = s_q.inactive;

    always_comb begin
        s_d          = s_q;
        s_d.clk_prev = mon_clk;
        s_d.ref_prev = ref_low;
        if (ref_low && fall) begin
            s_d.seen     = 1'b1;
            s_d.miss     = 2'h0;
            s_d.inactive = 1'b0;
        end
        // end of a reference-low window
        if (s_q.ref_prev && !ref_low) begin
            s_d.seen = 1'b0;
            if (!s_q.seen) begin
                if (s_q.miss + 2'h1 >= ccsm_pkg::MISS_LIMIT) begin
                    s_d.inactive = 1'b1;
                    s_d.miss     = ccsm_pkg::MISS_LIMIT;
                end else begin
                    s_d.miss = s_q.miss + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end
endmodule : ccsm_activity

//--- sim/ccsm_xosc.sv
// external clock source model: runs on request, stands low when stopped
`timescale 1ns/1ps
module ccsm_xosc #(
    parameter int HALF = 4      // system cycles per half period
) (
    input  wire logic aclk,     // system clock
    input  wire logic run,      // oscillator powered
    output logic      clk_out   // external clock
);
    int cnt = 0;
    initial clk_out = 1'h0;
    // a dead crystal gives no edges at all, so the line parks low
    always @(posedge aclk) begin
        cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
        if (!run) clk_out <= 1'h0;
        else if (cnt == HALF - 1) clk_out <= ~clk_out;
    end
endmodule : ccsm_xosc

//--- sim/ccsm_monitor.sv
// bus handshake and reset checks of the clock control block
`timescale 1ns/1ps
module ccsm_monitor (
    input wire logic        aclk,                 // clock
    input wire logic        aresetn,              // reset
    input wire logic        selected_osc_output,  // switched clock
    input wire logic        s_axi_awvalid,        // watched
    input wire logic        s_axi_awready,        // watched
    input wire logic        s_axi_wvalid,         // watched
    input wire logic        s_axi_wready,         // watched
    input wire logic        s_axi_bvalid,         // watched
    input wire logic        s_axi_bready,         // watched
    input wire logic [1:0]  s_axi_bresp,          // watched
    input wire logic        s_axi_arvalid,        // watched
    input wire logic        s_axi_arready,        // watched
    input wire logic        s_axi_rvalid,         // watched
    input wire logic        s_axi_rready,         // watched
    input wire logic [31:0] s_axi_rdata           // watched
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_aw_w;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_answer: assert property (s_ar |=> s_axi_rvalid) else $error("read answer late");
    a_write_answer: assert property (s_aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off");
    a_pair_held: assert property (s_aw_w |=> (!s_axi_awready && !s_axi_wready) [*2]) else $error("write reopened");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
    a_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !selected_osc_output)
        else $error("reset state wrong");
endmodule : ccsm_monitor
bind ccsm_top ccsm_monitor i_ccsm_monitor (.aclk, .aresetn, .selected_osc_output, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

//--- sim/ccsm_top_tb.sv
// self-checking bench of the clock control block
`timescale 1ns/1ps
module ccsm_top_tb;
    logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, internal_freq_ok = 1'h1, run = 1'h0;
    logic        corr_up = 1'h0, corr_down = 1'h0, corr_coarse = 1'h0, external_osc_clock;
    logic        internal_osc_clock, selected_osc_output, monitor_irq;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] dco_exp = 12'h000;
    int          bad_count = 0, checks_done = 0, i;
    time         t0;
    always #5 aclk = ~aclk;
    // short reference window keeps fault detection within a few hundred cycles
    ccsm_top #(.REF_HALF(64)) i_ccsm_top (.aclk, .aresetn, .ce, .external_osc_clock, .internal_freq_ok,
        .corr_up, .corr_down, .corr_coarse, .internal_osc_clock, .selected_osc_output, .monitor_irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ccsm_xosc #(.HALF(4)) i_ccsm_xosc (.aclk, .run, .clk_out(external_osc_clock));
    // ****************************************************************
    // expectations and bus tasks
    // ****************************************************************
    function logic [11:0] dco_next(input logic [11:0] v, input logic u, d, c);
        logic [12:0] s;
        s = c ? 13'h0020 : 13'h0001;
        // a step that would leave the range is dropped, the value stays
        if (u && !d) return ({1'h0, v} + s > 13'h09FF) ? v : v + s[11:0];
        if (d && !u) return ({1'h0, v} < s) ? v : v - s[11:0];
        return v;
    endfunction : dco_next
    always @(posedge aclk) if (aresetn && ce) dco_exp <= dco_next(dco_exp, corr_up, corr_down, corr_coarse);
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task fin;
        bad_count++;
        summarize();
    endtask : fin
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        tb = 1'h0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        for (n = 0; n < 50 && !tb; n++) begin
            @(negedge aclk);
            ta = w ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = w ? s_axi_bvalid : s_axi_rvalid;
            {rd, rr} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
            @(posedge aclk);
            if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tb) {s_axi_bready, s_axi_rready} <= 2'h0;
        end
        if (!tb) fin();
    endtask : bus
    task gap(input logic c, output int n);
        logic v;
        v = c ? selected_osc_output : internal_osc_clock;
        for (n = 0; n < 200 && (c ? selected_osc_output : internal_osc_clock) === v; n++) @(negedge aclk);
        v = ~v;
        for (n = 0; n < 200 && (c ? selected_osc_output : internal_osc_clock) === v; n++) @(negedge aclk);
        @(posedge aclk);
    endtask : gap
    task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'h0, a, '0);
        chk(rd & m, e);
    endtask : rc
    task corr(input int n, input logic rnd);
        for (i = 0; i < n; i++) begin
            @(posedge aclk);
            // ce drawn too: a frozen cycle must not step the value
            {ce, corr_up, corr_down, corr_coarse} <= rnd ? 4'($urandom) : 4'hD;
        end
        @(posedge aclk);
        {ce, corr_up, corr_down, corr_coarse} <= 4'h8;
        rc(8'h04, 32'hFFF, {20'h00000, dco_exp});
    endtask : corr
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h1D96));
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        gap(1'h0, i);
        chk(i, 32'h11);
        gap(1'h1, i);
        chk(i, 32'h11);
        rc(8'h00, 32'hFA, 32'h08);
        rc(8'h0C, 32'h0, 32'h0);
        chk(32'(rr), 32'h2);
        // select, clear internal, monitor and its enable all asked at once
        bus(1'h1, 8'h00, 32'hB0);
        rc(8'h00, 32'hFA, 32'h08);
        $display("test refusals done");
        run <= 1'h1;
        bus(1'h1, 8'h00, 32'h0A);
        t0 = $time;
        rc(8'h00, 32'h1, 32'h0);
        for (i = 0; i < 12000 && rd[0] !== 1'h1; i++) bus(1'h0, 8'h00, '0);
        if (rd[0] !== 1'h1) fin();
        chk(32'(($time - t0) >= 64'h4FFB0), 32'h1);
        bus(1'h1, 8'h00, 32'h1A);
        rc(8'h00, 32'hFA, 32'h1A);
        bus(1'h1, 8'h00, 32'h3A);
        bus(1'h1, 8'h00, 32'hBA);
        rc(8'h00, 32'hFA, 32'hBA);
        // handover takes up to two internal plus two external periods
        repeat (100) @(posedge aclk);
        gap(1'h1, i);
        chk(i, 32'h4);
        $display("test switch done");
        run <= 1'h0;
        for (i = 0; i < 2000 && monitor_irq !== 1'h1; i++) @(posedge aclk);
        chk(32'(monitor_irq), 32'h1);
        // external asked again and refused, so a cleared select proves the automatic flip
        bus(1'h1, 8'h00, 32'hBA);
        rc(8'h00, 32'hFA, 32'hCA);
        rc(8'h08, 32'h2, 32'h2);
        run <= 1'h1;
        for (i = 0; i < 300 && rd[1] !== 1'h0; i++) bus(1'h0, 8'h08, '0);
        if (rd[1] !== 1'h0) fin();
        bus(1'h1, 8'h00, 32'hAA);
        rc(8'h00, 32'h40, 32'h0);
        chk(32'(monitor_irq), 32'h0);
        $display("test monitor done");
        corr(300, 1'h1);
        corr(100, 1'h0);
        $display("test loop filter done");
        summarize();
    end
endmodule : ccsm_top_tb
